// [include/mbm_pkg.sv]
// Shared constants and types of the Modbus RTU master request framer.
// Assumes a single 100 MHz clock and byte streams to and from a UART.
package mbm_pkg;

  // Function codes.
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_REGS = 8'h03;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REGS = 8'h10;

  // Quantity limits and buffer depth.
  localparam logic [15:0] COIL_LIMIT = 16'h0190;
  localparam logic [15:0] WORD_LIMIT = 16'h0019;
  localparam int unsigned MAX_WORDS = 32'h0000_0019;
  localparam logic [15:0] COIL_WORD_RND = 16'h000F;
  localparam logic [15:0] COIL_BYTE_RND = 16'h0007;
  localparam int unsigned COIL_WORD_SH = 32'h0000_0004;
  localparam int unsigned COIL_BYTE_SH = 32'h0000_0003;

  // CRC16 engine.
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_OK = 16'h0000;
  localparam int unsigned BYTE_BITS = 32'h0000_0008;

  // Byte positions in request and reply frames.
  localparam logic [5:0] POS_ID = 6'h00;
  localparam logic [5:0] POS_FC = 6'h01;
  localparam logic [5:0] POS_ADR_H = 6'h02;
  localparam logic [5:0] POS_ADR_L = 6'h03;
  localparam logic [5:0] POS_QTY_H = 6'h04;
  localparam logic [5:0] POS_QTY_L = 6'h05;
  localparam logic [5:0] POS_BCNT = 6'h06;
  localparam logic [5:0] POS_WDATA = 6'h07;
  localparam logic [5:0] RSP_BCNT_POS = 6'h02;
  localparam logic [5:0] RD_DATA_POS = 6'h03;

  // Frame lengths.
  localparam logic [5:0] REQ_FIX_LEN = 6'h08;
  localparam logic [5:0] WREG_OVH = 6'h09;
  localparam logic [5:0] CRC_LEN = 6'h02;
  localparam logic [5:0] EXC_LEN = 6'h05;
  localparam logic [5:0] RD_RSP_OVH = 6'h05;

  // Reply timeout.
  localparam int unsigned RSP_TIMEOUT_US = 32'h0001_86A0;
  localparam int unsigned CLK_MHZ = 32'h0000_0064;
  localparam int unsigned RSP_TIMEOUT_CYC = RSP_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [1:0] {
    MODE_RD_COILS = 2'h0,
    MODE_WR_COIL = 2'h1,
    MODE_RD_REGS = 2'h2,
    MODE_WR_REGS = 2'h3
  } mbm_mode_t;

endpackage

// [rtl/mbm_crc16.sv]
// One byte step of the Modbus CRC16 (reflected polynomial).
// Purely combinational; the caller holds the running value.
module mbm_crc16 (
  input logic [15:0] crc_in,
  input logic [7:0] byte_in,
  output logic [15:0] crc_out
);

  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, byte_in};
    for (int b = 0; b < mbm_pkg::BYTE_BITS; b++) begin
      c = c[0] ? ((c >> 1) ^ mbm_pkg::CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end

endmodule

// [rtl/mbm_bus_request_block.sv]
// Modbus RTU master: builds request frames, checks replies, keeps a data buffer.
// Assumes a UART byte stream on clk; trigger and rx bytes come from the same clock.
module mbm_bus_request_block #(
  parameter int unsigned NWORDS = mbm_pkg::MAX_WORDS,
  parameter int unsigned RSP_TIMEOUT_CYC = mbm_pkg::RSP_TIMEOUT_CYC
) (
  input logic clk,
  input logic rst,
  input logic trigger,
  input mbm_pkg::mbm_mode_t mode,
  input logic [6:0] slave_id,
  input logic addr_is_reg,
  input logic [15:0] addr_const,
  input logic [15:0] count_const,
  input logic [15:0] address_source_reg,
  input logic [15:0] count_source_reg,
  input logic buf_wr_en,
  input logic [4:0] buf_wr_idx,
  input logic [15:0] buf_wr_data,
  input logic [4:0] buf_rd_idx,
  output logic [15:0] buf_rd_data,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input logic tx_ready,
  output logic tx_de,
  input logic [7:0] rx_data,
  input logic rx_valid,
  output logic busy,
  output logic done,
  output logic fail
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEND = 4'h2,
    ST_WAIT = 4'h4,
    ST_DONE = 4'h8
  } mbm_state_t;

  mbm_state_t state_r, state_nxt;
  logic trig_d_r;
  mbm_pkg::mbm_mode_t mode_r;
  logic [7:0] id_r, fc_r, bc_r, fc_w, bc_w;
  logic [15:0] addr_r, qty_r, words_r;
  logic [15:0] cnt_src_w, cnt_lim_w, qty_w, words_w;
  logic [5:0] tx_idx_r, tx_len_r, rx_idx_r, rx_len_r;
  logic [15:0] tx_crc_r, rx_crc_r, tx_crc_nxt, rx_crc_nxt;
  logic rx_bad_r;
  logic [31:0] tmo_r;
  logic [15:0] data_buf [NWORDS];
  logic [15:0] stage [NWORDS];
  logic [7:0] tx_data_r, tx_byte_w;
  logic tx_valid_r, tx_de_r, busy_r, done_r, fail_r;
  logic [15:0] buf_rd_data_r;

  wire start_w = (state_r == ST_IDLE) && trigger && !trig_d_r;
  wire rd_mode_w = (mode_r == mbm_pkg::MODE_RD_COILS) || (mode_r == mbm_pkg::MODE_RD_REGS);
  wire slot_w = !tx_valid_r || tx_ready;
  wire [5:0] tx_crc_pos_w = tx_len_r - mbm_pkg::CRC_LEN;
  wire rx_take_w = (state_r == ST_WAIT) && rx_valid;
  wire rx_last_w = rx_take_w && (rx_idx_r + 6'h01 == rx_len_r);
  wire tmo_hit_w = (state_r == ST_WAIT) && !rx_valid && (tmo_r == RSP_TIMEOUT_CYC - 1);
  wire ok_w = (rx_crc_r == mbm_pkg::CRC_OK) && !rx_bad_r;
  wire commit_w = (state_r == ST_DONE) && ok_w && rd_mode_w;
  wire [5:0] stage_off_w = rx_idx_r - mbm_pkg::RD_DATA_POS;
  wire stage_we_w = rx_take_w && rd_mode_w && (rx_idx_r >= mbm_pkg::RD_DATA_POS) &&
                    (stage_off_w < bc_r[5:0]);

  // Request field selection and quantity limits.
  always_comb begin
    cnt_src_w = addr_is_reg ? count_source_reg : count_const;
    cnt_lim_w = (mode == mbm_pkg::MODE_RD_COILS) ? mbm_pkg::COIL_LIMIT : mbm_pkg::WORD_LIMIT;
    qty_w = (cnt_src_w > cnt_lim_w) ? cnt_lim_w : cnt_src_w;
    case (mode)
      mbm_pkg::MODE_RD_COILS: fc_w = mbm_pkg::FC_RD_COILS;
      mbm_pkg::MODE_WR_COIL: fc_w = mbm_pkg::FC_WR_COIL;
      mbm_pkg::MODE_RD_REGS: fc_w = mbm_pkg::FC_RD_REGS;
      default: fc_w = mbm_pkg::FC_WR_REGS;
    endcase
    if (mode == mbm_pkg::MODE_RD_COILS) begin
      words_w = (qty_w + mbm_pkg::COIL_WORD_RND) >> mbm_pkg::COIL_WORD_SH;
      bc_w = 8'((qty_w + mbm_pkg::COIL_BYTE_RND) >> mbm_pkg::COIL_BYTE_SH);
    end else begin
      words_w = qty_w;
      bc_w = {qty_w[6:0], 1'b0};
    end
  end

  // Byte at position i of the request frame, CRC excluded.
  function automatic logic [7:0] frame_byte(input logic [5:0] i);
    logic [5:0] d;
    logic [15:0] w;
    d = i - mbm_pkg::POS_WDATA;
    w = data_buf[d[5:1]];
    case (i)
      mbm_pkg::POS_ID: frame_byte = id_r;
      mbm_pkg::POS_FC: frame_byte = fc_r;
      mbm_pkg::POS_ADR_H: frame_byte = addr_r[15:8];
      mbm_pkg::POS_ADR_L: frame_byte = addr_r[7:0];
      mbm_pkg::POS_QTY_H: frame_byte = (mode_r == mbm_pkg::MODE_WR_COIL) ?
                                       data_buf[0][15:8] : qty_r[15:8];
      mbm_pkg::POS_QTY_L: frame_byte = (mode_r == mbm_pkg::MODE_WR_COIL) ?
                                       data_buf[0][7:0] : qty_r[7:0];
      mbm_pkg::POS_BCNT: frame_byte = {qty_r[6:0], 1'b0};
      default: frame_byte = d[0] ? w[7:0] : w[15:8];
    endcase
  endfunction

  always_comb tx_byte_w = frame_byte(tx_idx_r);
  mbm_crc16 u_tx_crc (
    .crc_in(tx_crc_r),
    .byte_in(tx_byte_w),
    .crc_out(tx_crc_nxt)
  );

  mbm_crc16 u_rx_crc (
    .crc_in(rx_crc_r),
    .byte_in(rx_data),
    .crc_out(rx_crc_nxt)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start_w) state_nxt = ST_SEND;
      ST_SEND: if (slot_w && tx_idx_r == tx_len_r) state_nxt = ST_WAIT;
      ST_WAIT: begin
        if (rx_last_w) state_nxt = ST_DONE;
        else if (tmo_hit_w) state_nxt = ST_IDLE;
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      trig_d_r <= 1'b0;
      busy_r <= 1'b0;
      tx_de_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      trig_d_r <= trigger;
      busy_r <= state_nxt != ST_IDLE;
      tx_de_r <= state_nxt == ST_SEND;
      done_r <= (state_r == ST_DONE) && ok_w;
      fail_r <= ((state_r == ST_DONE) && !ok_w) || tmo_hit_w;
    end
  end

  // Request parameters are captured once per transaction.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= mbm_pkg::MODE_RD_COILS;
      id_r <= 8'h00;
      fc_r <= 8'h00;
      addr_r <= 16'h0000;
      qty_r <= 16'h0000;
      words_r <= 16'h0000;
      bc_r <= 8'h00;
      tx_len_r <= mbm_pkg::REQ_FIX_LEN;
    end else if (start_w) begin
      mode_r <= mode;
      id_r <= {1'b0, slave_id};
      fc_r <= fc_w;
      addr_r <= addr_is_reg ? address_source_reg : addr_const;
      qty_r <= qty_w;
      words_r <= words_w;
      bc_r <= bc_w;
      tx_len_r <= (mode == mbm_pkg::MODE_WR_REGS) ?
                  mbm_pkg::WREG_OVH + {qty_w[4:0], 1'b0} : mbm_pkg::REQ_FIX_LEN;
    end
  end

  // Transmit side; CRC goes out low byte first.
  always_ff @(posedge clk) begin
    if (rst || start_w) begin
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_idx_r <= 6'h00;
      tx_crc_r <= mbm_pkg::CRC_INIT;
    end else if (state_r == ST_SEND && slot_w) begin
      if (tx_idx_r < tx_len_r) begin
        tx_valid_r <= 1'b1;
        tx_idx_r <= tx_idx_r + 6'h01;
        if (tx_idx_r == tx_crc_pos_w) begin
          tx_data_r <= tx_crc_r[7:0];
        end else if (tx_idx_r > tx_crc_pos_w) begin
          tx_data_r <= tx_crc_r[15:8];
        end else begin
          tx_data_r <= frame_byte(tx_idx_r);
          tx_crc_r <= tx_crc_nxt;
        end
      end else begin
        tx_valid_r <= 1'b0;
      end
    end
  end

  // Receive side checks every header byte and the trailer residue.
  always_ff @(posedge clk) begin
    if (rst || start_w) begin
      rx_idx_r <= 6'h00;
      rx_len_r <= mbm_pkg::REQ_FIX_LEN;
      rx_crc_r <= mbm_pkg::CRC_INIT;
      rx_bad_r <= 1'b0;
    end else if (rx_take_w) begin
      rx_idx_r <= rx_idx_r + 6'h01;
      rx_crc_r <= rx_crc_nxt;
      if (rx_idx_r == mbm_pkg::POS_ID && rx_data != id_r) rx_bad_r <= 1'b1;
      if (rx_idx_r == mbm_pkg::POS_FC && rx_data != fc_r) begin
        rx_bad_r <= 1'b1;
        rx_len_r <= mbm_pkg::EXC_LEN;
      end
      if (rd_mode_w && !rx_bad_r && rx_idx_r == mbm_pkg::RSP_BCNT_POS) begin
        if (rx_data != bc_r) rx_bad_r <= 1'b1;
        rx_len_r <= bc_r[5:0] + mbm_pkg::RD_RSP_OVH;
      end
      if (!rd_mode_w && rx_idx_r >= mbm_pkg::POS_ADR_H && rx_idx_r <= mbm_pkg::POS_QTY_L &&
          rx_data != frame_byte(rx_idx_r)) rx_bad_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_r != ST_WAIT || rx_valid) tmo_r <= 32'h0000_0000;
    else tmo_r <= tmo_r + 32'h0000_0001;
  end

  // Reply words land in a staging copy and reach the buffer only on a clean frame.
  // A commit wins over a user write to the same word in the same cycle.
  for (genvar g = 0; g < NWORDS; g++) begin : g_word
    always_ff @(posedge clk) begin
      if (rst || start_w) begin
        stage[g] <= 16'h0000;
      end else if (stage_we_w && stage_off_w[5:1] == 5'(g)) begin
        if (stage_off_w[0]) stage[g][7:0] <= rx_data;
        else stage[g][15:8] <= rx_data;
      end
    end
    always_ff @(posedge clk) begin
      if (rst) data_buf[g] <= 16'h0000;
      else if (commit_w && 16'(g) < words_r) data_buf[g] <= stage[g];
      else if (buf_wr_en && buf_wr_idx == 5'(g)) data_buf[g] <= buf_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) buf_rd_data_r <= 16'h0000;
    else buf_rd_data_r <= data_buf[buf_rd_idx];
  end

  assign buf_rd_data = buf_rd_data_r;
  assign tx_data = tx_data_r;
  assign tx_valid = tx_valid_r;
  assign tx_de = tx_de_r;
  assign busy = busy_r;
  assign done = done_r;
  assign fail = fail_r;

  first_byte_a: assert property (@(posedge clk) disable iff (rst)
    start_w |-> ##2 tx_valid_r && tx_data_r == {1'b0, $past(slave_id, 2)})
    else $error("first request byte is not the slave id");
  coil_fc_a: assert property (@(posedge clk) disable iff (rst)
    start_w && mode == mbm_pkg::MODE_RD_COILS |=> fc_r == mbm_pkg::FC_RD_COILS)
    else $error("read coils function code wrong");
  addr_const_a: assert property (@(posedge clk) disable iff (rst)
    start_w && !addr_is_reg |=> addr_r == $past(addr_const))
    else $error("constant address not used");
  addr_reg_a: assert property (@(posedge clk) disable iff (rst)
    start_w && addr_is_reg |=> addr_r == $past(address_source_reg))
    else $error("address register not used");
  coil_limit_a: assert property (@(posedge clk) disable iff (rst)
    start_w && mode == mbm_pkg::MODE_RD_COILS && cnt_src_w > mbm_pkg::COIL_LIMIT
    |=> qty_r == mbm_pkg::COIL_LIMIT)
    else $error("coil quantity not clamped");
  word_limit_a: assert property (@(posedge clk) disable iff (rst)
    start_w && mode != mbm_pkg::MODE_RD_COILS |=> qty_r <= mbm_pkg::WORD_LIMIT)
    else $error("word quantity above limit");
  wreg_len_a: assert property (@(posedge clk) disable iff (rst)
    start_w && mode == mbm_pkg::MODE_WR_REGS
    |=> tx_len_r == mbm_pkg::WREG_OVH + {qty_r[4:0], 1'b0})
    else $error("write registers frame length wrong");
  tx_hold_a: assert property (@(posedge clk) disable iff (rst)
    tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
    else $error("tx byte dropped under stall");
  bad_frame_a: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_DONE && !ok_w |=> fail_r && !done_r && $stable(data_buf[0]))
    else $error("failed reply was not discarded");

endmodule

// [test/mbm_slave.sv]
// Behavioural remote slave station facing the request framer.
// Assumes one clock shared with the framer and byte streams on that clock.
module mbm_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_de,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic slow,
  input wire logic [1:0] err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] req [0:63];
  logic [7:0] rsp [0:63];
  int n = 0;
  int req_len = 0;
  int nframes = 0;
  int seed = 32'h0000_51a7;

  function automatic logic [15:0] crc16(input logic [7:0] b [0:63], input int cnt);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < cnt; i++) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  function automatic logic [7:0] pat(input int k);
    return 8'(k * 37 + 60);
  endfunction

  // Reads get a byte count and patterned data; writes are echoed; err 3 gives an exception.
  task automatic answer();
    int m;
    int bc;
    logic [15:0] c;
    m = 6;
    for (int k = 0; k < 6; k++) rsp[k] = req[k];
    if (req[1] == 8'h01 || req[1] == 8'h03) begin
      bc = 2 * int'({req[4], req[5]});
      if (req[1] == 8'h01) bc = (int'({req[4], req[5]}) + 7) / 8;
      rsp[2] = 8'(bc);
      for (int k = 0; k < bc; k++) rsp[3 + k] = pat(k);
      m = 3 + bc;
    end
    if (err == 2'h3) begin
      rsp[1] = rsp[1] | 8'h80;
      rsp[2] = 8'h02;
      m = 3;
    end
    c = crc16(rsp, m) ^ {15'h0000, err == 2'h1};
    rsp[m] = c[7:0];
    rsp[m + 1] = c[15:8];
    for (int k = 0; k < m + 2; k++) begin
      rx_data <= rsp[k];
      rx_valid <= 1'b1;
      @(posedge clk);
      if (slow || k == m + 1) begin
        rx_valid <= 1'b0;
        rx_data <= ~rsp[k];
      end
      if (slow) begin
        repeat (3) @(posedge clk);
      end
    end
  endtask

  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    forever begin
      @(posedge clk);
      tx_ready <= slow ? 1'($random(seed)) : 1'b1;
      if (rst) begin
        n = 0;
      end else if (tx_valid && tx_ready) begin
        req[n] = tx_data;
        n = n + 1;
      end else if (!tx_de && n > 0) begin
        req_len = n;
        nframes = nframes + 1;
        n = 0;
        if (err != 2'h2) begin
          answer();
        end
      end
    end
  end
endmodule

// [test/mbm_bus_request_block_test.sv]
// Self-checking bench of the request framer against a behavioural slave.
// Assumes the framer and slave model share one 100 MHz clock.
module mbm_bus_request_block_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, trigger, addr_is_reg, buf_wr_en, tx_valid, tx_ready, tx_de;
  logic rx_valid, busy, done, fail, slow;
  mbm_pkg::mbm_mode_t mode;
  logic [6:0] slave_id;
  logic [15:0] addr_const, count_const, address_source_reg, count_source_reg;
  logic [4:0] buf_wr_idx, buf_rd_idx;
  logic [15:0] buf_wr_data, buf_rd_data;
  logic [7:0] tx_data, rx_data;
  logic [1:0] err;
  logic [15:0] shadow [0:24];
  logic [7:0] exp_f [0:63];
  logic [7:0] fc [0:3] = '{8'h01, 8'h05, 8'h03, 8'h10};
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'h0000_2e5d;

  mbm_bus_request_block #(.RSP_TIMEOUT_CYC(200)) mbm_bus_request_block_inst (
    .clk(clk), .rst(rst), .trigger(trigger), .mode(mode), .slave_id(slave_id),
    .addr_is_reg(addr_is_reg), .addr_const(addr_const), .count_const(count_const),
    .address_source_reg(address_source_reg), .count_source_reg(count_source_reg),
    .buf_wr_en(buf_wr_en), .buf_wr_idx(buf_wr_idx), .buf_wr_data(buf_wr_data),
    .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_de(tx_de), .rx_data(rx_data),
    .rx_valid(rx_valid), .busy(busy), .done(done), .fail(fail));

  mbm_slave mbm_slave_inst (.clk(clk), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_de(tx_de), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .slow(slow), .err(err));

  always #5 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    total_checks++;
    if (seen !== expv) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      tally_and_finish();
    end
  end

  function automatic logic [7:0] pat(input int k);
    return 8'(k * 37 + 60);
  endfunction

  // Modbus CRC16 over the first cnt expected request bytes.
  function automatic logic [15:0] crc_of(input int cnt);
    logic [15:0] c;
    c = mbm_pkg::CRC_INIT;
    for (int i = 0; i < cnt; i++) begin
      c = c ^ {8'h00, exp_f[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ mbm_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  task automatic put(input int w, input logic [15:0] v);
    @(negedge clk);
    buf_wr_en = 1'b1;
    buf_wr_idx = 5'(w);
    buf_wr_data = v;
    shadow[w] = v;
    @(negedge clk);
    buf_wr_en = 1'b0;
  endtask

  // One transaction; a second trigger edge is given while busy and must be lost.
  task automatic run(input logic [1:0] md, input logic [6:0] id, input logic isreg,
                     input logic [15:0] adr, input logic [15:0] cnt, input logic [1:0] e);
    logic [15:0] q;
    int f0, nb, t;
    @(negedge clk);
    mode = mbm_pkg::mbm_mode_t'(md);
    slave_id = id;
    addr_is_reg = isreg;
    err = e;
    addr_const = isreg ? ~adr : adr;
    count_const = isreg ? ~cnt : cnt;
    address_source_reg = isreg ? adr : ~adr;
    count_source_reg = isreg ? cnt : ~cnt;
    buf_rd_idx = 5'h00;
    f0 = mbm_slave_inst.nframes;
    trigger = 1'b1;
    repeat (2) @(negedge clk);
    trigger = 1'b0;
    check("busy", {15'h0000, busy}, 16'h0001);
    @(negedge clk);
    trigger = 1'b1;
    t = 0;
    while (done !== 1'b1 && fail !== 1'b1 && t < 2000) begin
      check("buf early", buf_rd_data, shadow[0]);
      @(negedge clk);
      t++;
    end
    trigger = 1'b0;
    check("outcome", {14'h0000, done, fail}, (e == 2'h0) ? 16'h0002 : 16'h0001);
    if (e == 2'h3) check("exc quick", {15'h0000, t < 32'h0000_0096}, 16'h0001);
    q = (cnt > 16'h0019) ? 16'h0019 : cnt;
    if (md == 2'h0) q = (cnt > 16'h0190) ? 16'h0190 : cnt;
    exp_f[0] = {1'b0, id};
    exp_f[1] = fc[md];
    {exp_f[2], exp_f[3]} = adr;
    {exp_f[4], exp_f[5]} = (md == 2'h1) ? shadow[0] : q;
    exp_f[6] = 8'(2 * q);
    nb = (md == 2'h3) ? 7 + 2 * int'(q) : 6;
    for (int w = 0; w < int'(q) && md == 2'h3; w++) begin
      {exp_f[7 + 2 * w], exp_f[8 + 2 * w]} = shadow[w];
    end
    check("req len", 16'(mbm_slave_inst.req_len), 16'(nb + 2));
    for (int k = 0; k < nb; k++) begin
      check("req byte", {8'h00, mbm_slave_inst.req[k]},
            {8'h00, exp_f[k]});
    end
    check("req crc", {mbm_slave_inst.req[nb + 1], mbm_slave_inst.req[nb]},
          crc_of(nb));
    check("frames", 16'(mbm_slave_inst.nframes - f0), 16'h0001);
    if (e == 2'h0 && !md[0]) begin
      nb = (md == 2'h0) ? (int'(q) + 7) / 8 : 2 * int'(q);
      for (int w = 0; 2 * w < nb; w++) begin
        shadow[w] = {pat(2 * w), (2 * w + 1 < nb) ? pat(2 * w + 1) : 8'h00};
      end
    end
    repeat (3) @(negedge clk);
    check("idle", {15'h0000, busy}, 16'h0000);
    for (int w = 0; w < 25; w++) begin
      buf_rd_idx = 5'(w);
      @(negedge clk);
      check("buf word", buf_rd_data, shadow[w]);
    end
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {trigger, addr_is_reg, buf_wr_en, slow} = 4'h0;
    mode = mbm_pkg::MODE_RD_COILS;
    slave_id = 7'h01;
    {addr_const, count_const, address_source_reg, count_source_reg} = 64'h0000_0000_0000_0000;
    {buf_wr_idx, buf_rd_idx, buf_wr_data, err} = 28'h000_0000;
    for (int w = 0; w < 25; w++) shadow[w] = 16'h0000;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    run(2'h0, 7'h01, 1'b0, 16'h0020, 16'h0010, 2'h0);
    run(2'h0, 7'h01, 1'b1, 16'h0001, 16'h000f, 2'h0);
    run(2'h0, 7'h7f, 1'b1, 16'hffff, 16'h03e8, 2'h0);
    put(0, 16'hff00);
    run(2'h1, 7'h01, 1'b1, 16'h0001, 16'h0000, 2'h0);
    put(0, 16'h2710);
    put(1, 16'h1f40);
    put(2, 16'h1770);
    put(3, 16'h0fa0);
    // Alternate writes and reads of four words as a toggling trigger would.
    for (int i = 0; i < 2; i++) begin
      slow = 1'(i);
      run(2'h3, 7'h01, 1'b1, 16'h000e, 16'h0004, 2'h0);
      run(2'h2, 7'h01, 1'b1, 16'h000e, 16'h0004, 2'h0);
    end
    run(2'h3, 7'h00, 1'b0, 16'h1234, 16'h0040, 2'h0);
    run(2'h2, 7'h05, 1'b1, 16'h0000, 16'h0040, 2'h0);
    run(2'h2, 7'h01, 1'b0, 16'h0003, 16'h0002, 2'h1);
    run(2'h2, 7'h01, 1'b0, 16'h0003, 16'h0004, 2'h3);
    run(2'h0, 7'h01, 1'b0, 16'h0003, 16'h0011, 2'h2);
    for (int i = 0; i < 24; i++) begin
      slow = 1'($random(seed));
      if (i % 4 == 0) put(i % 25, 16'($random(seed)));
      run(2'($random(seed)), 7'($random(seed)), 1'($random(seed)), 16'($random(seed)),
          16'h0001 + 16'($random(seed) & 32'h0000_01ff), (i % 5 == 0) ? 2'h1 : 2'h0);
    end
    tally_and_finish();
  end
endmodule
